// ==== pkg/lbw_pkg.sv ====
// package: register map, fields, reset values and types for the lin break/autobaud/wake serial block
package lbw_pkg;
	// ========================================
	// register offsets
	localparam logic [3:0] ADDR_BAUD_CTRL = 4'h0;
	localparam logic [3:0] ADDR_DIV_LOW = 4'h1;
	localparam logic [3:0] ADDR_DIV_HIGH = 4'h2;
	localparam logic [3:0] ADDR_RX_STAT = 4'h3;
	localparam logic [3:0] ADDR_TX_STAT = 4'h4;
	localparam logic [3:0] ADDR_RX_DATA = 4'h5;
	localparam logic [3:0] ADDR_TX_DATA = 4'h6;
	localparam logic [3:0] ADDR_FLAGS = 4'h7;
	// ========================================
	// baud control fields
	localparam int BIT_AB_OVF = 7;
	localparam int BIT_RX_IDLE = 6;
	localparam int BIT_WAKE_EN = 1;
	localparam int BIT_AB_EN = 0;
	// rx status fields
	localparam int BIT_RX_EN = 7;
	localparam int BIT_FRAME_ERR = 2;
	// tx status fields
	localparam int BIT_TX_EN = 5;
	localparam int BIT_SEND_BREAK = 3;
	localparam int BIT_TX_SHIFT_EMPTY = 1;
	// flags register fields
	localparam int BIT_RX_IRQ = 5;
	localparam int BIT_TX_IRQ = 4;
	// ========================================
	// sizes and reset values
	localparam int BREAK_ZERO_BITS = 12;
	localparam int DATA_BITS = 8;
	localparam int AB_RISE_EDGES = 5;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	localparam logic [15:0] AB_COUNT_START = 16'h0001;
	localparam logic [2:0] AB_PRESCALE_LAST = 3'h7;
	localparam int SAMPLE_PHASES = 16;
	// ========================================
	// types
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} lbw_rx_e;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} lbw_tx_e;
	typedef enum logic [1:0] {AB_OFF, AB_WAIT_START, AB_MEASURE} lbw_ab_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lbw_bus_s;
endpackage

// ==== rtl/lbw_uart.sv ====
// lin serial block: autobaud with overflow, wake on break, break send and receive
`timescale 1ns/10ps
// Contract
// - autobaud counts from first rise, ends clearing enable
// - wake plus autobaud measures the byte after break
// - counter overflow before fifth rise sets overflow flag
// - overflow also sets receive interrupt flag
// - counter keeps running until the fifth rise
// - idle flag low during measurement, set at fifth
// - read after overflow, fifth rise sets interrupt again
// - early autobaud clear makes later falls start bits
// - wake enable halts reception, watches for wake
// - falling receive edge is wake, sets interrupt
// - wake interrupt synchronous here, async path external
// - rising edge ending break clears wake enable
// - reading receive data clears wake interrupt
// - nonzero character low time counts as wake
// - break is start, twelve zeros, stop
// - break started by data write, value ignored
// - send break cleared after stop, preload follows
// - shift empty flag tracks break like normal
// - received break gives interrupt, framing error, zero
// - wake mode: interrupt on break, then data interrupt
// - autobaud may be armed before sleep
module lbw_uart #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,

	// register port
	input wire lbw_pkg::lbw_bus_s i_bus,
	output logic [7:0] o_rdata,

	// serial pins
	input wire logic i_rx,
	output logic o_tx,

	// flags
	output logic o_rx_irq,
	output logic o_tx_irq
);

	typedef lbw_pkg::lbw_ab_e lbw_ab_st;
	typedef lbw_pkg::lbw_rx_e lbw_rx_st;
	typedef lbw_pkg::lbw_tx_e lbw_tx_st;

	typedef struct packed {
		logic [7:0] rdata;
		logic rx_q;
		logic ab_en;
		logic wake_en;
		logic ab_ovf;
		logic rx_en;
		logic tx_en;
		logic send_break;
		logic frame_err;
		logic rx_irq;
		logic wake_pend;
		logic [DIV_W-1:0] div;
		lbw_ab_st ab_st;
		logic [2:0] ab_pre;
		logic [2:0] ab_rises;
		logic ab_after_wake;
		lbw_rx_st rx_st;
		logic [DIV_W+3:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] rx_data;
		lbw_tx_st tx_st;
		logic [DIV_W+3:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_brk;
		logic [7:0] tx_buf;
		logic tx_buf_full;
		logic tx_buf_brk;
		logic tx_o;
	} st_s;

	st_s s;
	st_s next_s;
	logic fall;
	logic rise;
	logic [DIV_W+3:0] bit_len;

	// ========================================
	// helpers
	function automatic logic [DIV_W+3:0] bit_time(input logic [DIV_W-1:0] d);
		bit_time = {d, 4'h0} + (DIV_W+4)'(lbw_pkg::SAMPLE_PHASES);
	endfunction

	// one step of a bit-time counter
	function automatic logic [DIV_W+3:0] count_down(input logic [DIV_W+3:0] c);
		count_down = c - (DIV_W+4)'(1);
	endfunction
	function automatic logic count_done(input logic [DIV_W+3:0] c);
		count_done = c == '0;
	endfunction

	// receiver idle as software sees it
	function automatic logic rx_quiet(input lbw_rx_st r, input lbw_ab_st a);
		rx_quiet = r == lbw_pkg::RX_IDLE && a != lbw_pkg::AB_MEASURE;
	endfunction
	// level of a data bit on the line, zero for a break
	function automatic logic tx_level(input logic brk, input logic b);
		tx_level = brk ? 1'b0 : b;
	endfunction
	assign fall = s.rx_q & ~i_rx;
	assign rise = ~s.rx_q & i_rx;
	assign bit_len = bit_time(s.div);

	// ========================================
	// next state
	always_comb begin
		next_s = s;
		next_s.rx_q = i_rx;

		// ========================================
		// register writes
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				lbw_pkg::ADDR_BAUD_CTRL: begin
					next_s.ab_en = i_bus.wdata[lbw_pkg::BIT_AB_EN];
					next_s.wake_en = i_bus.wdata[lbw_pkg::BIT_WAKE_EN];
					next_s.wake_pend = 1'b0;
					if (!i_bus.wdata[lbw_pkg::BIT_AB_OVF]) begin
						next_s.ab_ovf = 1'b0;
					end
					if (!i_bus.wdata[lbw_pkg::BIT_AB_EN]) begin
						next_s.ab_st = lbw_pkg::AB_OFF;
					end
				end
				lbw_pkg::ADDR_DIV_LOW: begin
					next_s.div[7:0] = i_bus.wdata;
				end
				lbw_pkg::ADDR_DIV_HIGH: begin
					next_s.div[DIV_W-1:8] = i_bus.wdata[DIV_W-9:0];
				end
				lbw_pkg::ADDR_RX_STAT: begin
					next_s.rx_en = i_bus.wdata[lbw_pkg::BIT_RX_EN];
				end
				lbw_pkg::ADDR_TX_STAT: begin
					next_s.tx_en = i_bus.wdata[lbw_pkg::BIT_TX_EN];
					next_s.send_break = i_bus.wdata[lbw_pkg::BIT_SEND_BREAK];
				end
				lbw_pkg::ADDR_TX_DATA: begin
					if (!s.tx_buf_full) begin
						next_s.tx_buf = i_bus.wdata;
						next_s.tx_buf_full = 1'b1;
						// a byte written while the break is on the line is the preload
						next_s.tx_buf_brk = s.send_break & s.tx_en
							& ~(s.tx_brk & s.tx_st != lbw_pkg::TX_IDLE);
					end
				end
				default: ;
			endcase
		end

		// ========================================
		// read of receive data clears the interrupt
		if (i_bus.rd && i_bus.addr == lbw_pkg::ADDR_RX_DATA) begin
			next_s.rx_irq = 1'b0;
		end

		// ========================================
		// wake on break
		if (s.wake_en) begin
			next_s.rx_st = lbw_pkg::RX_IDLE;
			if (fall) begin
				next_s.rx_irq = 1'b1;
				next_s.wake_pend = 1'b1;
			end else if (rise && s.wake_pend) begin
				// fall kept apart from the interrupt, so a read cannot lose the end of break
				next_s.wake_en = 1'b0;
				next_s.wake_pend = 1'b0;
				next_s.ab_after_wake = s.ab_en;
			end
		end

		// ========================================
		// autobaud
		else if (s.ab_en) begin
			next_s.rx_st = lbw_pkg::RX_IDLE;
			unique case (s.ab_st)
				lbw_pkg::AB_OFF: begin
					next_s.ab_st = lbw_pkg::AB_WAIT_START;
				end

				lbw_pkg::AB_WAIT_START: begin
					next_s.ab_after_wake = 1'b0;
					if (rise && !i_bus.wr) begin
						next_s.ab_st = lbw_pkg::AB_MEASURE;
						next_s.div = DIV_W'(lbw_pkg::AB_COUNT_START);
						next_s.ab_pre = 3'h0;
						next_s.ab_rises = 3'h1;
					end
				end

				lbw_pkg::AB_MEASURE: begin
					next_s.ab_pre = s.ab_pre + 3'h1;
					if (s.ab_pre == lbw_pkg::AB_PRESCALE_LAST) begin
						next_s.div = s.div + DIV_W'(1);
						if (&s.div) begin
							next_s.ab_ovf = 1'b1;
							next_s.rx_irq = 1'b1;
						end
					end
					if (rise) begin
						next_s.ab_rises = s.ab_rises + 3'h1;
						if (s.ab_rises == 3'(lbw_pkg::AB_RISE_EDGES - 1)) begin
							next_s.ab_en = 1'b0;
							next_s.ab_st = lbw_pkg::AB_OFF;
							next_s.rx_irq = 1'b1;
						end
					end
				end
				default: begin
					next_s.ab_st = lbw_pkg::AB_OFF;
				end
			endcase
		end

		// ========================================
		// normal receive
		else if (s.rx_en) begin
			unique case (s.rx_st)
				lbw_pkg::RX_IDLE: begin
					if (fall) begin
						next_s.rx_st = lbw_pkg::RX_DATA;
						next_s.rx_cnt = bit_len + (bit_len >> 1);
						next_s.rx_bit = 4'h0;
					end
				end

				lbw_pkg::RX_DATA: begin
					next_s.rx_cnt = count_down(s.rx_cnt);
					if (count_done(s.rx_cnt)) begin
						next_s.rx_sh = {i_rx, s.rx_sh[7:1]};
						next_s.rx_cnt = bit_len;
						next_s.rx_bit = s.rx_bit + 4'h1;
						if (s.rx_bit == 4'(lbw_pkg::DATA_BITS - 1)) begin
							next_s.rx_st = lbw_pkg::RX_STOP;
						end
					end
				end

				lbw_pkg::RX_STOP: begin
					next_s.rx_cnt = count_down(s.rx_cnt);
					if (count_done(s.rx_cnt)) begin
						next_s.rx_data = s.rx_sh;
						next_s.frame_err = ~i_rx;
						next_s.rx_irq = 1'b1;
						next_s.rx_st = lbw_pkg::RX_IDLE;
					end
				end

				default: begin
					next_s.rx_st = lbw_pkg::RX_IDLE;
				end
			endcase
		end

		// ========================================
		// transmit
		unique case (s.tx_st)
			lbw_pkg::TX_IDLE: begin
				next_s.tx_o = 1'b1;
				if (s.tx_buf_full && s.tx_en) begin
					next_s.tx_st = lbw_pkg::TX_START;
					next_s.tx_brk = s.tx_buf_brk;
					next_s.tx_sh = s.tx_buf_brk ? 8'h00 : s.tx_buf;
					next_s.tx_buf_full = 1'b0;
					next_s.tx_cnt = bit_len;
					next_s.tx_o = 1'b0;
				end
			end

			lbw_pkg::TX_START: begin
				next_s.tx_cnt = count_down(s.tx_cnt);
				if (count_done(s.tx_cnt)) begin
					next_s.tx_st = lbw_pkg::TX_DATA;
					next_s.tx_cnt = bit_len;
					next_s.tx_bit = 4'h0;
					next_s.tx_o = tx_level(s.tx_brk, s.tx_sh[0]);
				end
			end

			lbw_pkg::TX_DATA: begin
				next_s.tx_cnt = count_down(s.tx_cnt);
				if (count_done(s.tx_cnt)) begin
					next_s.tx_cnt = bit_len;
					next_s.tx_bit = s.tx_bit + 4'h1;
					next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
					next_s.tx_o = tx_level(s.tx_brk, s.tx_sh[1]);
					if (s.tx_bit == (s.tx_brk ? 4'(lbw_pkg::BREAK_ZERO_BITS - 1)
							: 4'(lbw_pkg::DATA_BITS - 1))) begin
						next_s.tx_st = lbw_pkg::TX_STOP;
						next_s.tx_o = 1'b1;
					end
				end
			end

			lbw_pkg::TX_STOP: begin
				next_s.tx_cnt = count_down(s.tx_cnt);
				if (count_done(s.tx_cnt)) begin
					next_s.tx_st = lbw_pkg::TX_IDLE;
					if (s.tx_brk) begin
						next_s.send_break = 1'b0;
					end
				end
			end
		endcase

		// ========================================
		// read data
		next_s.rdata = 8'h00;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				lbw_pkg::ADDR_BAUD_CTRL: begin
					next_s.rdata[lbw_pkg::BIT_AB_OVF] = s.ab_ovf;
					next_s.rdata[lbw_pkg::BIT_RX_IDLE] = rx_quiet(s.rx_st, s.ab_st);
					next_s.rdata[lbw_pkg::BIT_WAKE_EN] = s.wake_en;
					next_s.rdata[lbw_pkg::BIT_AB_EN] = s.ab_en;
				end
				lbw_pkg::ADDR_DIV_LOW: begin
					next_s.rdata = s.div[7:0];
				end
				lbw_pkg::ADDR_DIV_HIGH: begin
					next_s.rdata = 8'(s.div[DIV_W-1:8]);
				end
				lbw_pkg::ADDR_RX_STAT: begin
					next_s.rdata[lbw_pkg::BIT_RX_EN] = s.rx_en;
					next_s.rdata[lbw_pkg::BIT_FRAME_ERR] = s.frame_err;
				end
				lbw_pkg::ADDR_TX_STAT: begin
					next_s.rdata[lbw_pkg::BIT_TX_EN] = s.tx_en;
					next_s.rdata[lbw_pkg::BIT_SEND_BREAK] = s.send_break;
					next_s.rdata[lbw_pkg::BIT_TX_SHIFT_EMPTY] = s.tx_st == lbw_pkg::TX_IDLE;
				end
				lbw_pkg::ADDR_RX_DATA: begin
					next_s.rdata = s.rx_data;
				end
				lbw_pkg::ADDR_FLAGS: begin
					next_s.rdata[lbw_pkg::BIT_RX_IRQ] = s.rx_irq;
					next_s.rdata[lbw_pkg::BIT_TX_IRQ] = ~s.tx_buf_full;
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	// ========================================
	// state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
			s.rx_q <= 1'b1;
			s.tx_o <= 1'b1;
			s.div <= DIV_W'(lbw_pkg::DIV_RESET);
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	// ========================================
	// outputs
	assign o_rdata = s.rdata;
	assign o_tx = s.tx_o;
	assign o_rx_irq = s.rx_irq;
	assign o_tx_irq = ~s.tx_buf_full;
endmodule

// ==== sim/lbw_uart_sva.sv ====
// checker for the lin serial block
`timescale 1ns/10ps
module lbw_uart_chk #(
	parameter int DIV_W = 16
) (
	// clock, reset, bus
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire lbw_pkg::lbw_bus_s i_bus,
	// outputs and pins
	input wire logic [7:0] o_rdata,
	input wire logic i_rx,
	input wire logic o_tx,
	input wire logic o_rx_irq,
	input wire logic o_tx_irq
);
	// ========================================
	// helpers
	logic rd_rx;
	logic wr_tx;
	logic [15:0] div;
	int low;
	int brk;
	assign rd_rx = i_bus.rd && i_bus.addr == lbw_pkg::ADDR_RX_DATA;
	assign wr_tx = i_bus.wr && i_bus.addr == lbw_pkg::ADDR_TX_DATA;
	assign brk = 208 * (int'(div) + 1);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div <= 16'h0000;
			low <= 0;
		end else begin
			if (i_bus.wr && i_bus.addr == lbw_pkg::ADDR_DIV_LOW) div[7:0] <= i_bus.wdata;
			if (i_bus.wr && i_bus.addr == lbw_pkg::ADDR_DIV_HIGH) div[15:8] <= i_bus.wdata;
			low <= o_tx ? 0 : low + 1;
		end
	end
	// ========================================
	// assertions
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_rd_clr; rd_rx |=> !o_rx_irq; endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("irq kept after read");
	property p_irq_fall; $fell(o_rx_irq) |-> $past(rd_rx); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
	property p_unmap; i_bus.rd && i_bus.addr[3] |=> o_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_flag_rb; i_bus.rd && i_bus.addr == lbw_pkg::ADDR_FLAGS
		|=> o_rdata[lbw_pkg::BIT_RX_IRQ] == $past(o_rx_irq); endproperty
	a_flag_rb: assert property (p_flag_rb) else $error("flag readback");
	property p_tx_full; wr_tx && o_tx_irq |=> !o_tx_irq; endproperty
	a_tx_full: assert property (p_tx_full) else $error("buffer not taken");
	property p_tx_rdy; $fell(o_tx_irq) |-> $past(wr_tx); endproperty
	a_tx_rdy: assert property (p_tx_rdy) else $error("buffer filled alone");
	property p_tx_go; wr_tx && o_tx_irq && o_tx |-> ##[1:4] !o_tx; endproperty
	a_tx_go: assert property (p_tx_go) else $error("no start bit");
	property p_brk_max; low <= brk + 15; endproperty
	a_brk_max: assert property (p_brk_max) else $error("tx low too long");
	property p_brk_min; $rose(o_tx) && $past(low) > 100 |-> $past(low) >= brk - 2; endproperty
	a_brk_min: assert property (p_brk_min) else $error("break too short");
endmodule
bind lbw_uart lbw_uart_chk #(.DIV_W(DIV_W)) u_chk (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_rx(i_rx), .o_tx(o_tx), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq)
);

// ==== sim/lbw_node.sv ====
// remote serial node: sends frames, decodes the transmit line
`timescale 1ns/10ps
module lbw_node (
	// clock
	input wire logic i_clk,
	// serial pins
	output logic o_rx,
	input wire logic i_tx
);
	int brk_len = 0;
	logic [7:0] got[$];
	logic [7:0] b;
	initial o_rx = 1'b1;
	// ========================================
	// start, bits lsb first, stop; idle high
	task automatic send(input logic [15:0] v, input int nb, input int bt);
		o_rx <= 1'b0;
		repeat (bt) @(posedge i_clk);
		for (int k = 0; k < nb; k++) begin
			o_rx <= v[k];
			repeat (bt) @(posedge i_clk);
		end
		o_rx <= 1'b1;
		repeat (bt) @(posedge i_clk);
	endtask
	always begin
		@(negedge i_tx);
		repeat (16) @(posedge i_clk);
		for (int k = 0; k < 8; k++) begin
			repeat (32) @(posedge i_clk);
			b = {i_tx, b[7:1]};
		end
		wait (i_tx);
		got.push_back(b);
	end
	always begin
		@(negedge i_tx);
		for (int n = 1; !i_tx; n++) begin
			@(posedge i_clk);
			if (n > 100) brk_len = n;
		end
	end
endmodule

// ==== sim/lbw_uart_tb.sv ====
// testbench for the lin serial block
`timescale 1ns/10ps
module lbw_uart_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	lbw_pkg::lbw_bus_s bus = '0;
	logic [7:0] rdata;
	logic rx;
	logic tx;
	logic rx_irq;
	logic tx_irq;
	logic [7:0] d;
	int err_count = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	lbw_uart #(.DIV_W(10)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_bus(bus),
		.o_rdata(rdata), .i_rx(rx), .o_tx(tx), .o_rx_irq(rx_irq), .o_tx_irq(tx_irq));
	lbw_node node (.i_clk(clk), .o_rx(rx), .i_tx(tx));
	// ========================================
	// shared tasks
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '{a, v, 1'b0, 1'b0};
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b0};
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic wirq(input int n);
		for (int i = 0; i < n && rx_irq !== 1'b1; i++) @(posedge clk) #1;
		chk(rx_irq, 1'b1);
		if (rx_irq !== 1'b1) end_of_test();
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ========================================
	// scenarios
	task automatic t_tx_break();
		wr(lbw_pkg::ADDR_DIV_LOW, 8'h01);
		wr(lbw_pkg::ADDR_TX_STAT, 8'h28);
		wr(lbw_pkg::ADDR_TX_DATA, 8'hA5);
		wr(lbw_pkg::ADDR_TX_DATA, 8'h55);
		rd(lbw_pkg::ADDR_TX_STAT);
		chk({d[3], d[1]}, 2'b10);
		for (int i = 0; i < 2000 && node.got.size() < 2; i++) @(posedge clk);
		chk(node.got.size(), 2);
		if (node.got.size() < 2) end_of_test();
		chk(node.got[0], 8'h00);
		chk(node.got[1], 8'h55);
		chk(node.brk_len > 414 && node.brk_len < 431, 1'b1);
		repeat (40) @(posedge clk);
		rd(lbw_pkg::ADDR_TX_STAT);
		chk({d[3], d[1]}, 2'b01);
	endtask
	task automatic t_rx_break();
		wr(lbw_pkg::ADDR_RX_STAT, 8'h80);
		node.send(16'h0000, 12, 32);
		wirq(40);
		rd(lbw_pkg::ADDR_FLAGS);
		chk(d[lbw_pkg::BIT_RX_IRQ], 1'b1);
		rd(lbw_pkg::ADDR_RX_STAT);
		chk(d[lbw_pkg::BIT_FRAME_ERR], 1'b1);
		rd(lbw_pkg::ADDR_RX_DATA);
		chk(d, 8'h00);
	endtask
	task automatic t_wake();
		rd(lbw_pkg::ADDR_BAUD_CTRL);
		chk(d[lbw_pkg::BIT_RX_IDLE], 1'b1);
		wr(lbw_pkg::ADDR_BAUD_CTRL, 8'h02);
		fork
			node.send(16'h0000, 12, 32);
		join_none
		for (int i = 0; i < 10 && rx !== 1'b0; i++) @(posedge clk);
		wirq(3);
		rd(lbw_pkg::ADDR_RX_DATA);
		chk(rx_irq, 1'b0);
		for (int i = 0; i < 600 && rx !== 1'b1; i++) @(posedge clk);
		repeat (3) @(posedge clk);
		rd(lbw_pkg::ADDR_BAUD_CTRL);
		chk({d[lbw_pkg::BIT_WAKE_EN], rx_irq}, 2'b00);
		repeat (40) @(posedge clk);
		node.send(16'h003C, 8, 33);
		wirq(40);
		rd(lbw_pkg::ADDR_RX_DATA);
		chk(d, 8'h3C);
	endtask
	task automatic t_autobaud();
		wr(lbw_pkg::ADDR_BAUD_CTRL, 8'h01);
		node.send(16'h0055, 8, 32);
		wirq(40);
		rd(lbw_pkg::ADDR_BAUD_CTRL);
		chk(d[lbw_pkg::BIT_AB_EN], 1'b0);
		rd(lbw_pkg::ADDR_DIV_LOW);
		chk(d > 31 && d < 35, 1'b1);
		rd(lbw_pkg::ADDR_RX_DATA);
		wr(lbw_pkg::ADDR_BAUD_CTRL, 8'h01);
		fork
			node.send(16'h0055, 8, 1100);
		join_none
		wirq(10000);
		rd(lbw_pkg::ADDR_BAUD_CTRL);
		chk(d[7:6], 2'b10);
		rd(lbw_pkg::ADDR_RX_DATA);
		wirq(3000);
		rd(lbw_pkg::ADDR_BAUD_CTRL);
		chk(d[7:6], 2'b11);
		rd(lbw_pkg::ADDR_RX_DATA);
		wr(lbw_pkg::ADDR_BAUD_CTRL, 8'h00);
		rd(lbw_pkg::ADDR_BAUD_CTRL);
		chk(d[7], 1'b0);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk) #1;
		chk({tx, tx_irq, rx_irq}, 3'b110);
		rd(4'hB);
		chk(d, 8'h00);
		t_tx_break();
		t_rx_break();
		t_wake();
		t_autobaud();
		end_of_test();
	end
endmodule
